// [hw/bwc_map.svh]
// register offsets, field positions, reset values and timing counts
`ifndef BWC_MAP_SVH
`define BWC_MAP_SVH

`define BWC_CLK_CTRL_OFF    12'h008
`define BWC_RAIL_CTRL_OFF   12'h018
`define BWC_GPO_OFF         12'h01C
`define BWC_STATUS_OFF      12'h020

`define BWC_XSEL_BIT        0
`define BWC_XEN_BIT         1
`define BWC_IEN_BIT         2
`define BWC_EMU_BIT         3
`define BWC_SWDIS_BIT       4
`define BWC_REF_BIT         5

`define BWC_CLK_CTRL_RST    6'h00
`define BWC_CLK_BOOT_VAL    6'h04
`define BWC_RAIL_CTRL_RST   2'h3

`define BWC_SLOW_KHZ        32
`define BWC_PCLK_KHZ        40000
// dead-clock timeout: three slow periods of 31.25 us, in pclk cycles
`define BWC_DEAD_CYC        ((3 * `BWC_PCLK_KHZ) / `BWC_SLOW_KHZ)
`define BWC_GOOD_EDGES      4

`endif

// [hw/bwc_pkg.sv]
// types shared by the battery-well clock control modules
package bwc_pkg;
  typedef enum logic [2:0] {
    BWC_SRC_OFF,
    BWC_SRC_SE_EXT,
    BWC_SRC_XTAL,
    BWC_SRC_INT,
    BWC_SRC_SWITCHED
  } bwc_src_t;
endpackage : bwc_pkg

// [hw/bwc_mon_if.sv]
// carrier between the selector and the external clock monitor
interface bwc_mon_if;
  logic ext_lvl;
  logic arm;
  logic ext_good;
  modport ctrl (output ext_lvl, output arm, input ext_good);
  modport mon  (input ext_lvl, input arm, output ext_good);
endinterface : bwc_mon_if

// [hw/bwc_ext_monitor.sv]
// watches the external slow clock: dead on timeout, alive after good edges
`include "bwc_map.svh"
module bwc_ext_monitor
  import bwc_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // carrier
  bwc_mon_if.mon    mon
);
  localparam int DEAD_CYC = `BWC_DEAD_CYC;

  logic        prev_lvl;
  logic [12:0] idle_cnt;
  logic [2:0]  good_cnt;
  logic        good;

  wire edge_seen = mon.ext_lvl ^ prev_lvl;
  wire timed_out = (idle_cnt == 13'(DEAD_CYC));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_lvl <= 1'b0;
      idle_cnt <= 13'h0000;
      good_cnt <= 3'h0;
      good     <= 1'b0;
    end else begin
      prev_lvl <= mon.ext_lvl;
      if (!mon.arm || edge_seen) idle_cnt <= 13'h0000;
      else if (!timed_out) idle_cnt <= idle_cnt + 13'h0001;
      // several good edges before the external clock is trusted again
      if (!mon.arm || timed_out) begin
        good_cnt <= 3'h0;
        good     <= 1'b0;
      end else if (edge_seen && !good) begin
        good_cnt <= good_cnt + 3'h1;
        if (good_cnt == 3'(`BWC_GOOD_EDGES - 1)) good <= 1'b1;
      end
    end
  end
  assign mon.ext_good = good;

  dead_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    timed_out && mon.arm |=> !good) else $error("good stayed after dead clock");
endmodule : bwc_ext_monitor

// [hw/bwc_clock_ctrl.sv]
// battery-well slow clock source selection and output rail ownership
`include "bwc_map.svh"

//
// Contract
// - Internal-only mode with emulation 0 keeps the internal clock running when the rail is off.
// - Internal-only mode with emulation 1 gates the internal clock off when the rail is off.
// - Switched mode runs on the single-ended clock, substituting internal when dead or rail off.
// - In switched mode the internal clock runs with the rail off only when emulation is 0.
// - A boot exception rewrites the clock control register to 04h, enabling the internal clock.
// - Output ownership 0 drives the battery output from the GPO register with rail on, else floats.
// - Output ownership 1, the reset default, drives the battery output from its battery data bit.
// - Control ownership 0 drives the control output from the GPO register with rail on, else floats.
// - Control ownership 1, the reset default, drives the control output from the control logic.
// - Select 0 uses a crystal across both pins, select 1 a single-ended clock on the second pin.
// - External enable 0 disables every external source; 1 enables the selected one.
// - The switcher falls back on a dead clock, returns after good edges, only with rail on.
module bwc_clock_ctrl
  import bwc_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // boot and rail status
  input  wire logic        boot_exception,
  input  wire logic        main_standby_rail,
  // slow clock sources
  input  wire logic        int_osc_clk,
  input  wire logic        osc_pin2_in,
  input  wire logic        xtal_clk,
  output      logic        xtal_amp_en,
  output      logic        slow_clk_out,
  output      logic        fast_ref_clk,
  output      logic        int_osc_run,
  // output pins
  input  wire logic        control_logic_out,
  output      logic        battery_backed_output_o,
  output      logic        battery_backed_output_oe,
  output      logic        battery_control_output_o,
  output      logic        battery_control_output_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [1:0] rail_s;
  logic [1:0] int_s;
  logic [1:0] se_s;
  logic [1:0] xt_s;
  logic [1:0] ctl_s;
  logic [1:0] boot_s;
  logic       boot_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rail_s    <= 2'h0;
      int_s     <= 2'h0;
      se_s      <= 2'h0;
      xt_s      <= 2'h0;
      ctl_s     <= 2'h0;
      boot_s    <= 2'h0;
      boot_prev <= 1'b0;
    end else begin
      rail_s    <= {rail_s[0], main_standby_rail};
      int_s     <= {int_s[0], int_osc_clk};
      se_s      <= {se_s[0], osc_pin2_in};
      xt_s      <= {xt_s[0], xtal_clk};
      ctl_s     <= {ctl_s[0], control_logic_out};
      boot_s    <= {boot_s[0], boot_exception};
      boot_prev <= boot_s[1];
    end
  end

  wire rail_on    = rail_s[1];
  wire int_lvl    = int_s[1];
  wire se_lvl     = se_s[1];
  wire xt_lvl     = xt_s[1];
  wire ctl_lvl    = ctl_s[1];
  wire boot_pulse = boot_s[1] & ~boot_prev;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [5:0] clk_ctrl;
  logic [1:0] rail_ctrl;
  logic [1:0] gpo;
  logic       battery_data;

  wire crystal_or_single_ended_select = clk_ctrl[`BWC_XSEL_BIT];
  wire external_slow_clock_enable     = clk_ctrl[`BWC_XEN_BIT];
  wire internal_slow_osc_enable       = clk_ctrl[`BWC_IEN_BIT];
  wire internal_clock_rail_emulation  = clk_ctrl[`BWC_EMU_BIT];
  wire switcher_disable               = clk_ctrl[`BWC_SWDIS_BIT];
  wire fast_ref_switched              = clk_ctrl[`BWC_REF_BIT];

  wire acc      = psel & penable;
  // writes land only at the edge that sees ready, when the master completes
  wire wr       = acc & pwrite & pready;
  wire hit_clk  = (paddr == `BWC_CLK_CTRL_OFF);
  wire hit_rail = (paddr == `BWC_RAIL_CTRL_OFF);
  wire hit_gpo  = (paddr == `BWC_GPO_OFF);
  wire hit_stat = (paddr == `BWC_STATUS_OFF);
  wire mapped   = hit_clk | hit_rail | hit_gpo | hit_stat;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ctrl     <= `BWC_CLK_CTRL_RST;
      rail_ctrl    <= `BWC_RAIL_CTRL_RST;
      gpo          <= 2'h0;
      battery_data <= 1'b0;
    end else begin
      // boot exception wins over a same-cycle software write
      if (boot_pulse) clk_ctrl <= `BWC_CLK_BOOT_VAL;
      else if (wr && hit_clk) clk_ctrl <= pwdata[5:0];
      if (wr && hit_rail) rail_ctrl <= pwdata[1:0];
      if (wr && hit_gpo) begin
        gpo          <= pwdata[1:0];
        battery_data <= pwdata[8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source decode
  bwc_src_t src;
  wire      en_pair = external_slow_clock_enable & internal_slow_osc_enable;
  assign src =
    (!external_slow_clock_enable && !internal_slow_osc_enable) ? BWC_SRC_OFF :
    (!external_slow_clock_enable) ? BWC_SRC_INT :
    (!crystal_or_single_ended_select) ? BWC_SRC_XTAL :
    (switcher_disable || !internal_slow_osc_enable) ? BWC_SRC_SE_EXT :
    (en_pair) ? BWC_SRC_SWITCHED : BWC_SRC_OFF;

  bwc_mon_if mon_c ();
  assign mon_c.ext_lvl = se_lvl;
  assign mon_c.arm     = (src == BWC_SRC_SWITCHED);

  bwc_ext_monitor u_mon (
    .pclk    (pclk),
    .presetn (presetn),
    .mon     (mon_c)
  );

  // internal clock is gated with the rail off when emulating the standby well
  wire int_allowed = rail_on | ~internal_clock_rail_emulation;

  // switching decisions only follow the monitor while the rail is up
  logic use_ext;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) use_ext <= 1'b0;
    else if (src != BWC_SRC_SWITCHED) use_ext <= 1'b0;
    else if (rail_on) use_ext <= mon_c.ext_good;
  end

  logic next_slow;
  logic int_needed;
  always_comb begin
    next_slow  = 1'b0;
    int_needed = 1'b0;
    case (src)
      BWC_SRC_OFF:    next_slow = 1'b0;
      BWC_SRC_SE_EXT: next_slow = se_lvl;
      BWC_SRC_XTAL:   next_slow = xt_lvl;
      BWC_SRC_INT: begin
        int_needed = int_allowed;
        next_slow  = int_lvl & int_allowed;
      end
      BWC_SRC_SWITCHED: begin
        int_needed = int_allowed;
        // rail off always falls back to internal
        next_slow  = (use_ext && rail_on) ? se_lvl : (int_lvl & int_allowed);
      end
      default:        next_slow = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin ownership
  wire bat_own = rail_ctrl[1];
  wire ctl_own = rail_ctrl[0];
  wire next_bat_o  = bat_own ? battery_data : gpo[1];
  wire next_bat_oe = bat_own | rail_on;
  wire next_ctl_o  = ctl_own ? ctl_lvl : gpo[0];
  wire next_ctl_oe = ctl_own | rail_on;

  wire [31:0] next_rdata =
    hit_clk  ? {26'h0, clk_ctrl} :
    hit_rail ? {30'h0, rail_ctrl} :
    hit_gpo  ? {23'h0, battery_data, 6'h00, gpo} :
    hit_stat ? {27'h0, use_ext, mon_c.ext_good, rail_on, src == BWC_SRC_OFF, int_needed} :
    32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_clk_out              <= 1'b0;
      fast_ref_clk              <= 1'b0;
      int_osc_run               <= 1'b0;
      xtal_amp_en               <= 1'b0;
      battery_backed_output_o   <= 1'b0;
      battery_backed_output_oe  <= 1'b0;
      battery_control_output_o  <= 1'b0;
      battery_control_output_oe <= 1'b0;
      prdata                    <= 32'h0000_0000;
      pready                    <= 1'b0;
      pslverr                   <= 1'b0;
    end else begin
      slow_clk_out              <= next_slow;
      fast_ref_clk              <= fast_ref_switched ? next_slow : (external_slow_clock_enable &
                                   (crystal_or_single_ended_select ? se_lvl : xt_lvl));
      int_osc_run               <= int_needed;
      xtal_amp_en               <= external_slow_clock_enable & ~crystal_or_single_ended_select;
      battery_backed_output_o   <= next_bat_o;
      battery_backed_output_oe  <= next_bat_oe;
      battery_control_output_o  <= next_ctl_o;
      battery_control_output_oe <= next_ctl_oe;
      // one-cycle-late ready: answer at the second access edge
      pready                    <= psel & penable & ~pready;
      pslverr                   <= psel & penable & ~pready & ~mapped;
      if (psel && penable && !pready && !pwrite) prdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  off_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (src == BWC_SRC_OFF) |=> !slow_clk_out) else $error("disabled clock not low");
  emu_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (src == BWC_SRC_INT && !rail_on && internal_clock_rail_emulation) |=> !slow_clk_out)
    else $error("internal clock not gated with rail off");
  int_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (src == BWC_SRC_INT && !internal_clock_rail_emulation) |=> (slow_clk_out == $past(int_lvl)))
    else $error("internal clock not passed");
  sw_int_a: assert property (@(posedge pclk) disable iff (!presetn)
    (src == BWC_SRC_SWITCHED && !rail_on) |-> (int_needed == !internal_clock_rail_emulation))
    else $error("switched internal enable wrong");
  sw_fallback_a: assert property (@(posedge pclk) disable iff (!presetn)
    (src == BWC_SRC_SWITCHED && !use_ext) |=> (slow_clk_out == $past(int_lvl & int_allowed)))
    else $error("no fallback to internal");
  se_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    (src == BWC_SRC_SE_EXT) |=> (slow_clk_out == $past(se_lvl) && !int_osc_run))
    else $error("single-ended only mode wrong");
  boot_val_a: assert property (@(posedge pclk) disable iff (!presetn)
    boot_pulse |=> (clk_ctrl == `BWC_CLK_BOOT_VAL)) else $error("boot value not loaded");
  bat_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!bat_own && !rail_on) |=> !battery_backed_output_oe) else $error("battery pin driven");
  bat_own_a: assert property (@(posedge pclk) disable iff (!presetn)
    bat_own |=> (battery_backed_output_oe && battery_backed_output_o == $past(battery_data)))
    else $error("battery data not driven");
  ctl_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctl_own && !rail_on) |=> !battery_control_output_oe) else $error("control pin driven");
  ctl_own_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_own |=> (battery_control_output_oe && battery_control_output_o == $past(ctl_lvl)))
    else $error("control logic not driven");
  xtal_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    !external_slow_clock_enable |=> !xtal_amp_en) else $error("crystal enabled while off");
  sw_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (src == BWC_SRC_SWITCHED && !rail_on) |=> (use_ext == $past(use_ext)))
    else $error("switch moved with rail off");

  // clock source paths
  int_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    (src == BWC_SRC_INT && !internal_clock_rail_emulation) |=> int_osc_run)
    else $error("internal oscillator stopped");
  sw_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
    (src == BWC_SRC_SWITCHED && use_ext && rail_on) |=> (slow_clk_out == $past(se_lvl)))
    else $error("external clock not used");
  xtal_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    (src == BWC_SRC_XTAL) |=> (slow_clk_out == $past(xt_lvl)))
    else $error("crystal clock not passed");
  xtal_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    (external_slow_clock_enable && !crystal_or_single_ended_select) |=> xtal_amp_en)
    else $error("crystal amplifier not enabled");
  sw_return_a: assert property (@(posedge pclk) disable iff (!presetn)
    (src == BWC_SRC_SWITCHED && rail_on && mon_c.ext_good) |=> use_ext)
    else $error("no return to external clock");
  off_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (src == BWC_SRC_OFF) |=> !int_osc_run)
    else $error("oscillator running while disabled");

  // pins owned by the standby rail
  bat_gpo_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!bat_own && rail_on) |=>
      (battery_backed_output_oe && battery_backed_output_o == $past(gpo[1])))
    else $error("battery pin not driven from gpo");
  ctl_gpo_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctl_own && rail_on) |=>
      (battery_control_output_oe && battery_control_output_o == $past(gpo[0])))
    else $error("control pin not driven from gpo");

  // apb handshake
  ready_next_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready) else $error("no ready after access");
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("ready held");
  err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready) else $error("error without ready");
endmodule : bwc_clock_ctrl

// [verif/bwc_ext_src.sv]
// external slow clock source: single-ended driver and crystal
module bwc_ext_src #(
  parameter int HALF_NS = 15625
) (
  // control
  input  wire logic run,
  input  wire logic amp_en,
  // pins
  output wire logic se_clk,
  output wire logic xtal_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ph = 1'b0;
  always #HALF_NS ph = ~ph;
  // a stopped source parks low, as a dead clock would
  assign se_clk   = run & ph;
  // a crystal only swings while its amplifier runs
  assign xtal_clk = run & amp_en & ph;
endmodule : bwc_ext_src

// [verif/bwc_clock_ctrl_tb.sv]
// self-checking bench for the battery-well clock control
module bwc_clock_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, xtal_amp_en, slow_clk_out, int_osc_run;
  logic        bb_o, bb_oe, bc_o, bc_oe, fref;
  logic        boot_exception = 1'b0;
  logic        main_standby_rail = 1'b1;
  logic        control_logic_out = 1'b0;
  logic        ext_run = 1'b1;
  logic        int_ph = 1'b0;
  wire logic   osc_pin2_in, xtal_clk, int_osc_clk;
  logic [3:0]  sh_i = 4'h0;
  logic [3:0]  sh_s = 4'h0;
  logic [32:0] exp_q[$];
  logic [32:0] obs_val;
  event        obs_ev;
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic [31:0] d;
  logic        cl;
  // {ctrl[5:0], expected source, amplifier on}; source 0 none, 1 internal, 2 external
  logic [8:0]  md [11] = '{9'h000, 9'h008, 9'h080, 9'h015, 9'h035, 9'h01C,
                           9'h0BC, 9'h09C, 9'h022, 9'h062, 9'h0A2};

  always #12.5 pclk = ~pclk;
  always #10000 int_ph = ~int_ph;
  assign int_osc_clk = int_osc_run & int_ph;
  always @(posedge pclk) begin
    sh_i <= {sh_i[2:0], int_ph};
    sh_s <= {sh_s[2:0], osc_pin2_in};
  end

  bwc_ext_src SRC (
    .run      (ext_run),
    .amp_en   (xtal_amp_en),
    .se_clk   (osc_pin2_in),
    .xtal_clk (xtal_clk)
  );

  bwc_clock_ctrl DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .boot_exception(boot_exception), .main_standby_rail(main_standby_rail),
    .int_osc_clk(int_osc_clk), .osc_pin2_in(osc_pin2_in), .xtal_clk(xtal_clk),
    .xtal_amp_en(xtal_amp_en), .slow_clk_out(slow_clk_out), .fast_ref_clk(fref),
    .int_osc_run(int_osc_run), .control_logic_out(control_logic_out),
    .battery_backed_output_o(bb_o), .battery_backed_output_oe(bb_oe),
    .battery_control_output_o(bc_o), .battery_control_output_oe(bc_oe)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic compare(input logic [32:0] got);
    logic [32:0] e;
    e = exp_q.pop_front();
    n_tests++;
    if (got !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask : compare

  always @(obs_ev) compare(obs_val);
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) compare({pslverr, prdata});
    cyc++;
    // the full sequence needs about 60k cycles
    if (cyc == 90000) begin
      err_total++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // entered just after a rising edge; reads note {pslverr, prdata} expected
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic [32:0] e);
    if (!w) exp_q.push_back(e);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // slow clock and fast reference against their expected sources, allowing sync slop
  task automatic observe(input logic [1:0] k, input logic amp, input logic [1:0] kr);
    int   mis;
    int   mr;
    logic e;
    logic er;
    mis = 0;
    mr  = 0;
    repeat (20) @(posedge pclk);
    repeat (2000) begin
      @(posedge pclk);
      e  = (k == 2'd1) ? sh_i[3] : (k == 2'd2) ? sh_s[3] : 1'b0;
      er = (kr == 2'd1) ? sh_i[3] : (kr == 2'd2) ? sh_s[3] : 1'b0;
      if (slow_clk_out !== e) mis++;
      if (fref !== er) mr++;
    end
    exp_q.push_back({32'h0, amp});
    obs_val = {30'h0, mr > 40, mis > 40, xtal_amp_en};
    -> obs_ev;
  endtask : observe

  // {battery oe, battery o, control oe, control o}; m masks o of floating pins
  task automatic pins(input logic [3:0] e, input logic m);
    repeat (8) @(posedge pclk);
    exp_q.push_back({29'h0, e});
    obs_val = {29'h0, bb_oe, bb_o & m, bc_oe, bc_o & m};
    -> obs_ev;
  endtask : pins

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h1a82));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    cl = 1'($urandom);
    control_logic_out <= cl;
    @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0, 33'h0);
    apb(1'b0, 12'h018, 32'h0, 33'h3);
    apb(1'b0, 12'h010, 32'h0, 33'h1_0000_0000);
    d = $urandom & 32'h0000_0103;
    apb(1'b1, 12'h01C, d, 33'h0);
    apb(1'b0, 12'h01C, 32'h0, {1'b0, d});
    pins({1'b1, d[8], 1'b1, cl}, 1'b1);
    apb(1'b1, 12'h018, 32'h0, 33'h0);
    pins({1'b1, d[1], 1'b1, d[0]}, 1'b1);
    main_standby_rail <= 1'b0;
    pins(4'b0000, 1'b0);
    main_standby_rail <= 1'b1;
    @(posedge pclk);
    apb(1'b1, 12'h018, 32'hFFFF_FFFF, 33'h0);
    apb(1'b0, 12'h018, 32'h0, 33'h3);
    main_standby_rail <= 1'b0;
    control_logic_out <= ~cl;
    pins({1'b1, d[8], 1'b1, ~cl}, 1'b1);
    main_standby_rail <= 1'b1;
    @(posedge pclk);
    foreach (md[i]) begin
      apb(1'b1, 12'h008, {26'h0, md[i][8:3]}, 33'h0);
      observe(md[i][2:1], md[i][0], md[i][4] ? 2'd2 : 2'd0);
    end
    apb(1'b1, 12'h008, 32'h07, 33'h0);
    repeat (6000) @(posedge pclk);
    observe(2'd2, 1'b0, 2'd2);
    ext_run <= 1'b0;
    repeat (4500) @(posedge pclk);
    observe(2'd1, 1'b0, 2'd2);
    ext_run <= 1'b1;
    repeat (6500) @(posedge pclk);
    observe(2'd2, 1'b0, 2'd2);
    main_standby_rail <= 1'b0;
    observe(2'd1, 1'b0, 2'd2);
    apb(1'b1, 12'h008, 32'h0F, 33'h0);
    observe(2'd0, 1'b0, 2'd2);
    apb(1'b1, 12'h008, 32'h0C, 33'h0);
    observe(2'd0, 1'b0, 2'd0);
    apb(1'b1, 12'h008, 32'h04, 33'h0);
    observe(2'd1, 1'b0, 2'd0);
    apb(1'b1, 12'h008, 32'h24, 33'h0);
    observe(2'd1, 1'b0, 2'd1);
    main_standby_rail <= 1'b1;
    @(posedge pclk);
    apb(1'b1, 12'h008, 32'hFFFF_FFFF, 33'h0);
    apb(1'b0, 12'h008, 32'h0, 33'h3F);
    boot_exception <= 1'b1;
    repeat (4) @(posedge pclk);
    boot_exception <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0, 33'h04);
    apb(1'b0, 12'h020, 32'h0, 33'h05);
    // battery power-on reset again in mid-run: defaults come back
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0, 33'h0);
    apb(1'b0, 12'h018, 32'h0, 33'h3);
    pins({1'b1, 1'b0, 1'b1, ~cl}, 1'b1);
    tally_and_finish();
  end
endmodule : bwc_clock_ctrl_tb
